// ===== inc/legacy_region_defines.svh
// Offsets, field positions, reset values and address ranges of the legacy region decoder.
// Plain definitions; included by the package and by the design file.
`ifndef LEGACY_REGION_DEFINES_SVH
`define LEGACY_REGION_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFF_LEGACY_LOW   16'h8004
`define OFF_EXPANSION    16'h8008
`define OFF_BIOS         16'h800c
`define OFF_IRQ_STATUS   16'h8010
`define OFF_IRQ_MASK     16'h8014

`define RESET_WORD       32'h00000000
`define RESET_FIELD      4'h0

// ----------------------------------------------------------------
// Legacy map low fields
// ----------------------------------------------------------------
`define BIT_TRAP_3D      15
`define BIT_TRAP_3C      14
`define BIT_TRAP_3B      13
`define BIT_PIPE_DIS     7
`define BIT_GFX_NOWAIT   6
`define BIT_BIU_NOWAIT   5
`define BIT_GFX_A        4
`define LEGACY_RW_MASK   32'h0000e0ff

// ----------------------------------------------------------------
// Region control field bits
// ----------------------------------------------------------------
`define FLD_READ_EN      0
`define FLD_WRITE_EN     1
`define FLD_CACHE_EN     2
`define FLD_PCI_EN       3

// ----------------------------------------------------------------
// Address ranges (upper address digits)
// ----------------------------------------------------------------
`define SEG_A            4'ha
`define SEG_C            4'hc
`define SEG_D            4'hd
`define SEG_E            4'he
`define SEG_F            4'hf
`define IO_3B            12'h03b
`define IO_3C            12'h03c
`define IO_3D            12'h03d

// Status / mask bit positions
`define EV_3B            0
`define EV_3C            1
`define EV_3D            2
`define EV_WIDTH         3

`endif

// ===== inc/legacy_region_pkg.sv
// Types shared by the legacy region decoder.
// Assumes the defines header is on the include path.
`include "legacy_region_defines.svh"

package legacy_region_pkg;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_EARLY,
    PH_STROBE
  } phase_e;

  typedef struct packed {
    logic [31:0]            legacyLow;
    logic [31:0]            expMap;
    logic [31:0]            biosMap;
    logic [`EV_WIDTH-1:0]   irqStatus;
    logic [`EV_WIDTH-1:0]   irqMask;
    logic                   irq;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic                   respValid;
    logic                   routeLocal;
    logic                   routePci;
    logic                   routeGfx;
    logic                   cacheable;
    logic                   pciSlaveOk;
    logic                   regionMapped;
    logic                   smiPulse;
    phase_e                 phase;
    logic                   xbusDataDrive;
    logic                   xbusDataStrobe;
    logic                   xbusReady;
    logic                   addrPipelineOk;
  } state_s;

endpackage

// ===== logic/legacy_region_decode.sv
// Legacy memory region attribute decode, VGA I/O trap and X-Bus timing options.
// Assumes one clock, synchronous inputs, an APB master and one request at a time.
`timescale 1ns/1ps
`default_nettype none
`include "legacy_region_defines.svh"

// Notes on behaviour
// - Enabled trap: any I/O access in 3D0h-3DFh raises a system management interrupt.
// - Bit 14 enables the trap for I/O accesses within 3C0h-3CFh.
// - Bit 13 enables the trap for I/O accesses within 3B0h-3BFh.
// - Bit 7 clear allows next address before data phase ends; set disables.
// - Graphics data: bit 6 low drives one clock early, high same clock.
// - Bus unit data: bit 5 low drives one clock early, high same clock.
// - Bit 4 routes memory accesses of the A window to graphics.
// - With graphics routing, the A window is uncacheable, cache bit ignored.
// - Bits 3:0 of legacy low register control the A window.
// - Expansion map low nibbles control the four C windows, ascending.
// - Expansion map high nibbles control the four D windows, ascending.
// - BIOS map low nibbles control the four E windows, ascending.
// - BIOS map high nibbles control the four F windows, ascending.
// - Expansion and BIOS map registers reset to all zeros.
// - Field bit 0 allows local reads, bit 1 local writes; else PCI.
// - Field bit 2 clear inhibits caching of the window.
// - Field bit 3 lets PCI slave in only with matching read/write enable.
module legacy_region_decode
  import legacy_region_pkg::*;
#(
  parameter int ADDR_WIDTH = 16
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_WIDTH-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  reqValid,
  input  wire logic                  reqIo,
  input  wire logic                  reqWrite,
  input  wire logic                  reqFromPci,
  input  wire logic [19:0]           reqAddr,
  output logic                       respValid,
  output logic                       routeLocal,
  output logic                       routePci,
  output logic                       routeGfx,
  output logic                       cacheable,
  output logic                       pciSlaveOk,
  output logic                       regionMapped,
  output logic                       smiPulse,
  input  wire logic                  dataReq,
  input  wire logic                  dataFromGfx,
  output logic                       xbusDataDrive,
  output logic                       xbusDataStrobe,
  output logic                       xbusReady,
  output logic                       addrPipelineOk,
  output logic                       irq
);

  state_s cur;
  state_s next_cur;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Returns {mapped, field} for a memory address; one nibble per window
  function automatic logic [4:0] regionField(
    input logic [19:0] addr,
    input logic [31:0] legacy,
    input logic [31:0] expMap,
    input logic [31:0] biosMap
  );
    logic [2:0] idx;
    logic [4:0] res;
    // Bit 16 picks the upper half, bits 15:14 the 16 KB slot
    idx = {addr[16], addr[15:14]};
    res = {1'b0, `RESET_FIELD};
    unique case (addr[19:16])
      `SEG_A: res = {1'b1, legacy[3:0]};
      `SEG_C, `SEG_D: res = {1'b1, expMap[idx*4 +: 4]};
      `SEG_E, `SEG_F: res = {1'b1, biosMap[idx*4 +: 4]};
      default: res = {1'b0, `RESET_FIELD};
    endcase
    return res;
  endfunction

  // I/O trap hit for the three VGA ranges, gated by their enables
  function automatic logic [`EV_WIDTH-1:0] ioTrap(
    input logic [19:0] addr,
    input logic [31:0] legacy
  );
    logic [`EV_WIDTH-1:0] hit;
    hit = '0;
    if (addr[19:16] == 4'h0) begin
      hit[`EV_3B] = (addr[15:4] == `IO_3B) && legacy[`BIT_TRAP_3B];
      hit[`EV_3C] = (addr[15:4] == `IO_3C) && legacy[`BIT_TRAP_3C];
      hit[`EV_3D] = (addr[15:4] == `IO_3D) && legacy[`BIT_TRAP_3D];
    end
    return hit;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [4:0]           fld;
    logic [`EV_WIDTH-1:0] trapHit;
    logic [`EV_WIDTH-1:0] clrBits;
    logic                 access;
    logic                 setup;
    logic                 known;
    logic                 gfxA;
    logic                 enBit;
    logic                 noWait;
    logic [31:0]          rdWord;
    fld = '0;
    trapHit = '0;
    clrBits = '0;
    access = 1'b0;
    setup = 1'b0;
    known = 1'b0;
    gfxA = 1'b0;
    enBit = 1'b0;
    noWait = 1'b0;
    rdWord = '0;
    next_cur = cur;

    // APB: one setup cycle, then a zero-wait access phase
    setup = psel && !penable;
    access = psel && penable && cur.pready;
    known = 1'b1;
    unique case (paddr)
      `OFF_LEGACY_LOW: rdWord = cur.legacyLow;
      `OFF_EXPANSION:  rdWord = cur.expMap;
      `OFF_BIOS:       rdWord = cur.biosMap;
      `OFF_IRQ_STATUS: rdWord = {{(32-`EV_WIDTH){1'b0}}, cur.irqStatus};
      `OFF_IRQ_MASK:   rdWord = {{(32-`EV_WIDTH){1'b0}}, cur.irqMask};
      default: begin
        known = 1'b0;
        rdWord = '0;
      end
    endcase
    next_cur.pready = setup;
    next_cur.pslverr = setup && !known;
    next_cur.prdata = setup && !pwrite ? rdWord : '0;

    if (access && pwrite) begin
      unique case (paddr)
        // Reserved bits of the legacy word are not held and read zero
        `OFF_LEGACY_LOW: next_cur.legacyLow = pwdata & `LEGACY_RW_MASK;
        `OFF_EXPANSION:  next_cur.expMap = pwdata;
        `OFF_BIOS:       next_cur.biosMap = pwdata;
        `OFF_IRQ_STATUS: clrBits = pwdata[`EV_WIDTH-1:0];
        `OFF_IRQ_MASK:   next_cur.irqMask = pwdata[`EV_WIDTH-1:0];
        default: next_cur.irqMask = cur.irqMask;
      endcase
    end

    // ----------------------------------------------------------------
    // Access decode, answered one clock after the request
    // ----------------------------------------------------------------
    next_cur.respValid = reqValid;
    next_cur.routeLocal = 1'b0;
    next_cur.routePci = 1'b0;
    next_cur.routeGfx = 1'b0;
    next_cur.cacheable = 1'b0;
    next_cur.pciSlaveOk = 1'b0;
    next_cur.regionMapped = 1'b0;
    next_cur.smiPulse = 1'b0;
    if (reqValid && reqIo) begin
      trapHit = ioTrap(reqAddr, cur.legacyLow);
      next_cur.smiPulse = |trapHit;
      next_cur.routeLocal = !(|trapHit);
    end else if (reqValid) begin
      fld = regionField(reqAddr, cur.legacyLow, cur.expMap, cur.biosMap);
      gfxA = fld[4] && (reqAddr[19:16] == `SEG_A) && cur.legacyLow[`BIT_GFX_A];
      enBit = reqWrite ? fld[`FLD_WRITE_EN] : fld[`FLD_READ_EN];
      next_cur.regionMapped = fld[4];
      if (!fld[4]) begin
        // Outside the mapped windows: plain local memory
        next_cur.routeLocal = !reqFromPci;
        next_cur.cacheable = 1'b1;
      end else if (gfxA) begin
        next_cur.routeGfx = 1'b1;
        next_cur.cacheable = 1'b0;
        next_cur.pciSlaveOk = reqFromPci && fld[`FLD_PCI_EN] && enBit;
      end else if (reqFromPci) begin
        next_cur.pciSlaveOk = fld[`FLD_PCI_EN] && enBit;
        next_cur.routeLocal = fld[`FLD_PCI_EN] && enBit;
      end else begin
        next_cur.routeLocal = enBit;
        next_cur.routePci = !enBit;
        next_cur.cacheable = fld[`FLD_CACHE_EN];
      end
    end

    // ----------------------------------------------------------------
    // Sticky trap status; a new event wins over a clear
    // ----------------------------------------------------------------
    next_cur.irqStatus = (cur.irqStatus & ~clrBits) | trapHit;
    next_cur.irq = |(next_cur.irqStatus & next_cur.irqMask);

    // ----------------------------------------------------------------
    // X-Bus data phase timing
    // ----------------------------------------------------------------
    noWait = dataFromGfx ? cur.legacyLow[`BIT_GFX_NOWAIT]
                         : cur.legacyLow[`BIT_BIU_NOWAIT];
    next_cur.xbusDataDrive = 1'b0;
    next_cur.xbusDataStrobe = 1'b0;
    next_cur.xbusReady = 1'b0;
    unique case (cur.phase)
      PH_IDLE: begin
        if (dataReq && noWait) begin
          // Data, strobe and ready all in the one clock
          next_cur.phase = PH_STROBE;
          next_cur.xbusDataDrive = 1'b1;
          next_cur.xbusDataStrobe = 1'b1;
          next_cur.xbusReady = 1'b1;
        end else if (dataReq) begin
          // Data lead of one full clock before the strobe
          next_cur.phase = PH_EARLY;
          next_cur.xbusDataDrive = 1'b1;
        end
      end
      PH_EARLY: begin
        next_cur.phase = PH_STROBE;
        next_cur.xbusDataDrive = 1'b1;
        next_cur.xbusDataStrobe = 1'b1;
        next_cur.xbusReady = 1'b1;
      end
      PH_STROBE: begin
        next_cur.phase = PH_IDLE;
      end
      default: next_cur.phase = PH_IDLE;
    endcase
    // Next address may overlap only while a data phase is open
    next_cur.addrPipelineOk = (next_cur.phase != PH_IDLE) &&
                              !cur.legacyLow[`BIT_PIPE_DIS];
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      cur <= '0;
      cur.expMap <= `RESET_WORD;
      cur.biosMap <= `RESET_WORD;
      cur.phase <= PH_IDLE;
    end else if (ce) begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, straight from the state register
  // ----------------------------------------------------------------
  assign prdata = cur.prdata;
  assign pready = cur.pready;
  assign pslverr = cur.pslverr;
  assign respValid = cur.respValid;
  assign routeLocal = cur.routeLocal;
  assign routePci = cur.routePci;
  assign routeGfx = cur.routeGfx;
  assign cacheable = cur.cacheable;
  assign pciSlaveOk = cur.pciSlaveOk;
  assign regionMapped = cur.regionMapped;
  assign smiPulse = cur.smiPulse;
  assign xbusDataDrive = cur.xbusDataDrive;
  assign xbusDataStrobe = cur.xbusDataStrobe;
  assign xbusReady = cur.xbusReady;
  assign addrPipelineOk = cur.addrPipelineOk;
  assign irq = cur.irq;

endmodule

`default_nettype wire

// ===== test/legacy_region_checker.sv
// Port checker for the legacy region decoder.
// Bound to the decoder; mirrors the legacy low register from APB writes.
`timescale 1ns/1ps
`default_nettype none
`include "legacy_region_defines.svh"
module legacy_region_checker #(
  parameter int ADDR_WIDTH = 16
) (
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  ce,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0]           pwdata,
  input wire logic                  pready,
  input wire logic                  reqValid,
  input wire logic                  reqIo,
  input wire logic                  reqWrite,
  input wire logic                  reqFromPci,
  input wire logic [19:0]           reqAddr,
  input wire logic                  respValid,
  input wire logic                  routeLocal,
  input wire logic                  routePci,
  input wire logic                  routeGfx,
  input wire logic                  cacheable,
  input wire logic                  smiPulse,
  input wire logic                  dataReq,
  input wire logic                  dataFromGfx,
  input wire logic                  xbusDataDrive,
  input wire logic                  xbusDataStrobe,
  input wire logic                  xbusReady,
  input wire logic                  addrPipelineOk
);
  logic [31:0] shadow;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Mirror only what completed on the bus, so a refused access never leaks in
  always_ff @(posedge clk) begin
    if (rst) begin
      shadow <= '0;
    end else if (ce && psel && penable && pready && pwrite && paddr == `OFF_LEGACY_LOW) begin
      shadow <= pwdata;
    end
  end

  AST_TRAP_3D: assert property (ce && reqValid && reqIo && reqAddr[15:4] == `IO_3D
    |=> smiPulse == $past(shadow[15])) else $error("trap 3Dx wrong");
  AST_TRAP_3C: assert property (ce && reqValid && reqIo && reqAddr[15:4] == `IO_3C
    |=> smiPulse == $past(shadow[14])) else $error("trap 3Cx wrong");
  AST_TRAP_3B: assert property (ce && reqValid && reqIo && reqAddr[15:4] == `IO_3B
    |=> smiPulse == $past(shadow[13])) else $error("trap 3Bx wrong");
  // The flag is registered from the bit as it stood one cycle earlier
  AST_PIPELINE: assert property (addrPipelineOk == (xbusDataDrive && !$past(shadow[7])))
    else $error("pipelining flag wrong");
  AST_GFX_TIMING: assert property (ce && dataReq && dataFromGfx && !xbusDataDrive
    |=> xbusDataDrive && xbusDataStrobe == $past(shadow[6])) else $error("gfx data timing");
  AST_BIU_TIMING: assert property (ce && dataReq && !dataFromGfx && !xbusDataDrive
    |=> xbusDataDrive && xbusDataStrobe == $past(shadow[5])) else $error("biu data timing");
  AST_EARLY_LEAD: assert property ($rose(xbusDataDrive) && !xbusDataStrobe
    |=> xbusDataDrive && xbusDataStrobe && xbusReady ##1 !xbusDataDrive)
    else $error("early data lead wrong");
  AST_GFX_ROUTE: assert property (ce && reqValid && !reqIo && !reqFromPci
    && reqAddr[19:16] == `SEG_A |=> routeGfx == $past(shadow[4])) else $error("gfx route wrong");
  AST_GFX_NOCACHE: assert property (routeGfx
    |-> respValid && !cacheable && !routeLocal && !routePci) else $error("gfx region cached");
  AST_A_FIELD: assert property (ce && reqValid && !reqIo && !reqFromPci && !shadow[4]
    && reqAddr[19:16] == `SEG_A |=> routePci != routeLocal
    && routeLocal == ($past(reqWrite) ? $past(shadow[1]) : $past(shadow[0])))
    else $error("A window field wrong");
endmodule

bind legacy_region_decode legacy_region_checker #(.ADDR_WIDTH(ADDR_WIDTH)) checker0 (
  .clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .reqValid, .reqIo,
  .reqWrite, .reqFromPci, .reqAddr, .respValid, .routeLocal, .routePci, .routeGfx, .cacheable,
  .smiPulse, .dataReq, .dataFromGfx, .xbusDataDrive, .xbusDataStrobe, .xbusReady,
  .addrPipelineOk
);
`default_nettype wire

// ===== test/xbus_partner.sv
// X-Bus side model: issues access requests and data phase starts.
// Assumes its tasks are called from one bench process.
`timescale 1ns/1ps
`default_nettype none
module xbus_partner (
  input  wire logic        clk,
  output logic             reqValid,
  output logic             reqIo,
  output logic             reqWrite,
  output logic             reqFromPci,
  output logic [19:0]      reqAddr,
  output logic             dataReq,
  output logic             dataFromGfx
);
  initial begin
    {reqValid, reqIo, reqWrite, reqFromPci, dataReq, dataFromGfx} = '0;
    reqAddr = '0;
  end

  // Address is scrambled after the pulse so stale values are never trusted
  task automatic access(input logic io, input logic wr, input logic pci, input logic [19:0] a);
    @(posedge clk);
    reqValid <= 1'b1;
    reqIo <= io;
    reqWrite <= wr;
    reqFromPci <= pci;
    reqAddr <= a;
    @(posedge clk);
    reqValid <= 1'b0;
    reqAddr <= ~a;
  endtask

  task automatic startData(input logic gfx);
    @(posedge clk);
    dataReq <= 1'b1;
    dataFromGfx <= gfx;
    @(posedge clk);
    dataReq <= 1'b0;
    dataFromGfx <= ~gfx;
  endtask
endmodule
`default_nettype wire

// ===== test/legacy_region_decode_bench.sv
// Self-checking bench for the legacy region decoder.
// Drives APB itself and X-Bus requests through the partner model.
`timescale 1ns/1ps
`default_nettype none
`include "legacy_region_defines.svh"
module legacy_region_decode_bench;
  logic        clk;
  logic        rst;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        reqValid, reqIo, reqWrite, reqFromPci, dataReq, dataFromGfx;
  logic [19:0] reqAddr;
  logic        respValid, routeLocal, routePci, routeGfx, cacheable, pciSlaveOk;
  logic        regionMapped, smiPulse, xbusDataDrive, xbusDataStrobe, xbusReady;
  logic        addrPipelineOk, irq, err, nw;
  logic [31:0] rd;
  int          n_errors = 0;
  int          checks = 0;
  int          cycles = 0;

  typedef struct packed {
    logic [15:0] off;
    logic [31:0] data;
    logic [19:0] addr;
    logic        wr;
    logic        pci;
    logic [3:0]  exp;
  } row_s;
  // exp = {local, pci master, cacheable, pci slave ok}
  row_s rows [9] = '{
    '{`OFF_EXPANSION,  32'h00000005, 20'hc0000, 1'b0, 1'b0, 4'b1010},
    '{`OFF_EXPANSION,  32'h00000005, 20'hc4000, 1'b0, 1'b0, 4'b0100},
    '{`OFF_EXPANSION,  32'h30000000, 20'hdffff, 1'b1, 1'b0, 4'b1000},
    '{`OFF_EXPANSION,  32'h00500000, 20'hd4000, 1'b0, 1'b0, 4'b1010},
    '{`OFF_BIOS,       32'h00000a00, 20'he8000, 1'b1, 1'b1, 4'b1001},
    '{`OFF_BIOS,       32'h00000a00, 20'he8000, 1'b0, 1'b1, 4'b0000},
    '{`OFF_BIOS,       32'h40000000, 20'hfc000, 1'b0, 1'b0, 4'b0110},
    '{`OFF_BIOS,       32'h00000002, 20'he3fff, 1'b1, 1'b0, 4'b1000},
    '{`OFF_LEGACY_LOW, 32'h00000001, 20'ha0000, 1'b0, 1'b0, 4'b1000}
  };

  legacy_region_decode uut (
    .clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .reqValid, .reqIo, .reqWrite, .reqFromPci, .reqAddr, .respValid, .routeLocal,
    .routePci, .routeGfx, .cacheable, .pciSlaveOk, .regionMapped, .smiPulse, .dataReq,
    .dataFromGfx, .xbusDataDrive, .xbusDataStrobe, .xbusReady, .addrPipelineOk, .irq
  );

  xbus_partner partner (
    .clk, .reqValid, .reqIo, .reqWrite, .reqFromPci, .reqAddr, .dataReq, .dataFromGfx
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic doReset();
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
  endtask

  // Hang guard, far above the couple of hundred cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst, psel, penable, pwrite} = 4'h8;
    ce = 1'b1;
    paddr = '0;
    pwdata = '0;
    doReset();
    foreach (rows[i]) begin
      apb(1'b1, rows[i].off, rows[i].data);
      partner.access(1'b0, rows[i].wr, rows[i].pci, rows[i].addr);
      #1;
      check("route", {28'h0, rows[i].exp},
            {28'h0, routeLocal, routePci, cacheable, pciSlaveOk});
      check("mapped", 32'h3, {30'h0, respValid, regionMapped});
    end
    // Reset again from a clock edge, with nothing in flight
    @(posedge clk);
    doReset();
    apb(1'b0, `OFF_EXPANSION, 32'h0);
    check("expansion reset", 32'h0, rd);
    apb(1'b0, `OFF_BIOS, 32'h0);
    check("bios reset", 32'h0, rd);
    apb(1'b0, 16'h8000, 32'h0);
    check("unmapped", 32'h1, {31'h0, err});
    apb(1'b1, `OFF_LEGACY_LOW, 32'hffffffff);
    apb(1'b0, `OFF_LEGACY_LOW, 32'h0);
    check("legacy bits", 32'h0000e0ff, rd);
    apb(1'b1, `OFF_IRQ_MASK, 32'h0);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `OFF_LEGACY_LOW, 32'h1 << (13 + i));
      for (int j = 0; j < 3; j++) begin
        partner.access(1'b1, j[0], 1'b0, {8'h00, 12'h03b + 12'(j), j[0] ? 4'hf : 4'h0});
        #1;
        check("smiPulse", {31'h0, i == j}, {31'h0, smiPulse});
      end
    end
    check("irq masked", 32'h0, {31'h0, irq});
    apb(1'b0, `OFF_IRQ_STATUS, 32'h0);
    check("status", 32'h7, rd);
    apb(1'b1, `OFF_IRQ_MASK, 32'h4);
    repeat (2) @(posedge clk);
    #1;
    check("irq set", 32'h1, {31'h0, irq});
    apb(1'b1, `OFF_IRQ_STATUS, 32'h4);
    repeat (2) @(posedge clk);
    #1;
    check("irq cleared", 32'h0, {31'h0, irq});
    // Trap and clear of the same status bit at one edge: the trap must win
    fork
      apb(1'b1, `OFF_IRQ_STATUS, 32'h4);
      begin
        @(posedge clk);
        partner.access(1'b1, 1'b0, 1'b0, 20'h003d0);
      end
    join
    apb(1'b0, `OFF_IRQ_STATUS, 32'h0);
    check("set wins", 32'h7, rd);
    apb(1'b1, `OFF_LEGACY_LOW, 32'h00000017);
    partner.access(1'b0, 1'b0, 1'b0, 20'ha4000);
    #1;
    check("gfx route", 32'h8, {28'h0, routeGfx, cacheable, routeLocal, routePci});
    for (int m = 0; m < 8; m++) begin
      nw = m[2] ? m[1] : m[0];
      apb(1'b1, `OFF_LEGACY_LOW, {24'h0, m[0] ^ m[1], m[1], m[0], 5'h0});
      partner.startData(m[2]);
      #1;
      check("phase first", {29'h0, 1'b1, nw, !(m[0] ^ m[1])},
            {29'h0, xbusDataDrive, xbusDataStrobe, addrPipelineOk});
      @(posedge clk);
      #1;
      check("phase second", {30'h0, !nw, !nw}, {30'h0, xbusDataDrive, xbusDataStrobe});
      @(posedge clk);
    end
    // Unmapped window; ce low must then hold the answer one more cycle
    partner.access(1'b0, 1'b0, 1'b0, 20'hb0000);
    ce <= 1'b0;
    #1;
    check("unmapped route", 32'hb, {28'h0, respValid, regionMapped, routeLocal, cacheable});
    @(posedge clk);
    #1;
    check("ce freeze", 32'hb, {28'h0, respValid, regionMapped, routeLocal, cacheable});
    @(posedge clk);
    ce <= 1'b1;
    end_of_test();
  end
endmodule
`default_nettype wire
